// File: twm_pkg.sv
/*
  shared constants, types and register map for the 16-bit timer waveform block.
  assumes a single system clock domain and a plain register port.
*/
`default_nettype none

package twm_pkg;

  localparam int unsigned TWM_DW     = 16;
  localparam int unsigned TWM_AW     = 4;
  localparam int unsigned TWM_NCH    = 2;
  localparam int unsigned TWM_MODE_W = 4;
  localparam int unsigned TWM_COM_W  = 2;

  // waveform_mode_select codes
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_NORMAL    = 4'h0;
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_CTC_CMPA  = 4'h4;
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_FAST_8    = 4'h5;
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_FAST_9    = 4'h6;
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_FAST_10   = 4'h7;
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_CTC_CAP   = 4'hc;
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_FAST_CAP  = 4'he;
  localparam logic [TWM_MODE_W-1:0] TWM_WGM_FAST_CMPA = 4'hf;

  // counter limits
  localparam logic [TWM_DW-1:0] TWM_BOTTOM  = 16'h0000;
  localparam logic [TWM_DW-1:0] TWM_MAX     = 16'hffff;
  localparam logic [TWM_DW-1:0] TWM_TOP_8   = 16'h00ff;
  localparam logic [TWM_DW-1:0] TWM_TOP_9   = 16'h01ff;
  localparam logic [TWM_DW-1:0] TWM_TOP_10  = 16'h03ff;
  localparam logic [TWM_DW-1:0] TWM_ONE     = 16'h0001;

  // compare_output_mode_field codes
  localparam logic [TWM_COM_W-1:0] TWM_COM_NONE   = 2'h0;
  localparam logic [TWM_COM_W-1:0] TWM_COM_TOGGLE = 2'h1;
  localparam logic [TWM_COM_W-1:0] TWM_COM_CLEAR  = 2'h2;
  localparam logic [TWM_COM_W-1:0] TWM_COM_SET    = 2'h3;

  // register offsets
  localparam logic [TWM_AW-1:0] TWM_REG_CTRL    = 4'h0;
  localparam logic [TWM_AW-1:0] TWM_REG_OUTMODE = 4'h1;
  localparam logic [TWM_AW-1:0] TWM_REG_FORCE   = 4'h2;
  localparam logic [TWM_AW-1:0] TWM_REG_COUNT   = 4'h3;
  localparam logic [TWM_AW-1:0] TWM_REG_CMPA    = 4'h4;
  localparam logic [TWM_AW-1:0] TWM_REG_CMPB    = 4'h5;
  localparam logic [TWM_AW-1:0] TWM_REG_CAPTURE = 4'h6;
  localparam logic [TWM_AW-1:0] TWM_REG_FLAGS   = 4'h7;
  localparam logic [TWM_AW-1:0] TWM_REG_PORT    = 4'h8;
  localparam logic [TWM_AW-1:0] TWM_REG_LATCH   = 4'h9;

  // flag bit positions
  localparam int unsigned TWM_FLG_OVF  = 0;
  localparam int unsigned TWM_FLG_CMP0 = 1;
  localparam int unsigned TWM_FLG_CAP  = 3;
  localparam int unsigned TWM_FLG_W    = 4;
  // port register: value bits then direction bits
  localparam int unsigned TWM_PORT_DIR = 2;

  localparam logic [TWM_DW-1:0] TWM_RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    TWM_KIND_NORMAL,
    TWM_KIND_CTC,
    TWM_KIND_FAST
  } twm_kind_type;

  typedef enum logic [1:0] {
    TWM_ACT_HOLD,
    TWM_ACT_SET,
    TWM_ACT_CLEAR,
    TWM_ACT_TOGGLE
  } twm_act_type;

  typedef struct packed {
    logic [TWM_AW-1:0] addr;
    logic [TWM_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } twm_bus_req_type;

  typedef struct packed {
    logic out;
    logic oe;
  } twm_pin_type;

endpackage : twm_pkg

`default_nettype wire

// File: twm_channel.sv
/*
  one compare channel: output latch, its action on match, top and force,
  and the port pin override.
  assumes match, top and force pulses are already qualified by the parent.
*/
`default_nettype none

module twm_channel
  import twm_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 match_hit,
  input  wire logic                 top_hit,
  input  wire logic                 force_hit,
  input  wire logic [TWM_COM_W-1:0] out_mode,
  input  wire twm_kind_type         kind,
  input  wire logic                 toggle_ok,
  input  wire logic                 port_value,
  input  wire logic                 direction,
  output logic                      latch,
  output twm_pin_type               pin
);

  logic        latch_r;
  logic        latch_nxt;
  twm_pin_type pin_r;
  twm_act_type act;

  // mode field is sampled at the event itself, so a new field waits for the next match, top or force
  always_comb begin
    act = TWM_ACT_HOLD;
    if (kind != TWM_KIND_FAST) begin
      if (match_hit || force_hit) begin
        case (out_mode)
          TWM_COM_TOGGLE: act = TWM_ACT_TOGGLE;
          TWM_COM_CLEAR:  act = TWM_ACT_CLEAR;
          TWM_COM_SET:    act = TWM_ACT_SET;
          default:        act = TWM_ACT_HOLD;
        endcase
      end
    end else if (match_hit) begin
      // match wins over top so compare equal to top gives a steady level in clear and set modes; toggle toggles on each match only on channel 0 in TWM_WGM_FAST_CMPA
      case (out_mode)
        TWM_COM_TOGGLE: act = toggle_ok ? TWM_ACT_TOGGLE : TWM_ACT_HOLD;
        TWM_COM_CLEAR:  act = TWM_ACT_SET;
        TWM_COM_SET:    act = TWM_ACT_CLEAR;
        default:        act = TWM_ACT_HOLD;
      endcase
    end else if (top_hit) begin
      case (out_mode)
        TWM_COM_CLEAR: act = TWM_ACT_CLEAR;
        TWM_COM_SET:   act = TWM_ACT_SET;
        default:       act = TWM_ACT_HOLD;
      endcase
    end
  end

  always_comb begin
    case (act)
      TWM_ACT_SET:    latch_nxt = 1'b1;
      TWM_ACT_CLEAR:  latch_nxt = 1'b0;
      TWM_ACT_TOGGLE: latch_nxt = ~latch_r;
      default:        latch_nxt = latch_r;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latch_r <= 1'b0;
    end else if (ce) begin
      latch_r <= latch_nxt;
    end
  end

  // pin registered: one cycle late, but glitch free toward the load
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_r <= '0;
    end else if (ce) begin
      pin_r.out <= (out_mode != TWM_COM_NONE) ? latch_r : port_value;
      pin_r.oe  <= direction;
    end
  end

  assign latch = latch_r;
  assign pin   = pin_r;

endmodule : twm_channel

`default_nettype wire

// File: twm_top.sv
/*
  16-bit timer waveform generation: counter, compare channels, flags and
  register port; normal, clear-on-match and fast pwm counting.
  assumes a prescaled timer tick on clk_sys and a master that never waits.
*/
`default_nettype none

module twm_top
  import twm_pkg::*;
#(
  parameter int unsigned NCH = TWM_NCH
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             tick,
  input  wire twm_bus_req_type  bus,
  input  wire logic             capture_event,
  output logic [TWM_DW-1:0]     rd_data,
  output logic [TWM_FLG_W-1:0]  flags,
  output twm_pin_type [NCH-1:0] pins
);

  logic [TWM_MODE_W-1:0]    waveform_mode_select_r;
  logic [TWM_COM_W-1:0]     compare_output_mode_field_r [NCH];
  logic [TWM_DW-1:0]        counter_value_r;
  logic [TWM_DW-1:0]        counter_value_nxt;
  logic [TWM_DW-1:0]        cmp_buf_r [NCH];
  logic [TWM_DW-1:0]        cmp_act_r [NCH];
  logic [TWM_DW-1:0]        capture_register_r;
  logic [TWM_FLG_W-1:0]     flags_r;
  logic [TWM_FLG_W-1:0]     flag_set;
  logic [TWM_FLG_W-1:0]     flag_clr;
  logic [NCH-1:0]           port_value_r;
  logic [NCH-1:0]           output_pin_direction_bit_r;
  logic [NCH-1:0]           latch_w;
  logic [NCH-1:0]           cmp_hit;
  logic [NCH-1:0]           force_hit;
  logic                     block_r;
  logic [TWM_DW-1:0]        rd_data_r;
  logic [TWM_DW-1:0]        rd_mux;
  logic [TWM_DW-1:0]        top_value;
  logic                     top_match;
  logic                     step;
  logic                     wr_en;
  twm_kind_type             kind;

  function automatic twm_kind_type mode_kind(input logic [TWM_MODE_W-1:0] m);
    case (m)
      TWM_WGM_CTC_CMPA, TWM_WGM_CTC_CAP: mode_kind = TWM_KIND_CTC;
      TWM_WGM_FAST_8, TWM_WGM_FAST_9, TWM_WGM_FAST_10,
      TWM_WGM_FAST_CAP, TWM_WGM_FAST_CMPA: mode_kind = TWM_KIND_FAST;
      // dual-slope modes are not built; they fall back to plain counting
      default: mode_kind = TWM_KIND_NORMAL;
    endcase
  endfunction : mode_kind

  function automatic logic top_is_cap(input logic [TWM_MODE_W-1:0] m);
    top_is_cap = (m == TWM_WGM_CTC_CAP) || (m == TWM_WGM_FAST_CAP);
  endfunction : top_is_cap

  function automatic logic top_is_cmpa(input logic [TWM_MODE_W-1:0] m);
    top_is_cmpa = (m == TWM_WGM_CTC_CMPA) || (m == TWM_WGM_FAST_CMPA);
  endfunction : top_is_cmpa

  // fixed-top modes keep compare words inside the counting range
  function automatic logic [TWM_DW-1:0] fixed_mask(input logic [TWM_MODE_W-1:0] m);
    case (m)
      TWM_WGM_FAST_8:  fixed_mask = TWM_TOP_8;
      TWM_WGM_FAST_9:  fixed_mask = TWM_TOP_9;
      TWM_WGM_FAST_10: fixed_mask = TWM_TOP_10;
      default:         fixed_mask = TWM_MAX;
    endcase
  endfunction : fixed_mask

  function automatic logic bus_wr(input twm_bus_req_type b, input logic [TWM_AW-1:0] a);
    bus_wr = b.wr && (b.addr == a);
  endfunction : bus_wr

  assign kind  = mode_kind(waveform_mode_select_r);
  assign step  = ce && tick;
  assign wr_en = ce && bus.wr;

  always_comb begin
    case (waveform_mode_select_r)
      TWM_WGM_FAST_8:  top_value = TWM_TOP_8;
      TWM_WGM_FAST_9:  top_value = TWM_TOP_9;
      TWM_WGM_FAST_10: top_value = TWM_TOP_10;
      TWM_WGM_CTC_CMPA, TWM_WGM_FAST_CMPA: top_value = cmp_act_r[0];
      TWM_WGM_CTC_CAP, TWM_WGM_FAST_CAP: top_value = capture_register_r;
      default: top_value = TWM_MAX;
    endcase
  end

  // a counter write hides matches for one tick, so no spurious event follows it
  assign top_match = (counter_value_r == top_value) && !block_r;

  always_comb begin
    case (kind)
      TWM_KIND_CTC:
        // exact compare only: a top below the count is passed over
        counter_value_nxt = top_match ? TWM_BOTTOM : counter_value_r + TWM_ONE;
      TWM_KIND_FAST:
        counter_value_nxt = top_match ? TWM_BOTTOM : counter_value_r + TWM_ONE;
      default:
        counter_value_nxt = counter_value_r + TWM_ONE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      counter_value_r <= TWM_RST_WORD;
    end else if (wr_en && bus.addr == TWM_REG_COUNT) begin
      counter_value_r <= bus.wdata;
    end else if (step) begin
      counter_value_r <= counter_value_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      block_r <= 1'b0;
    end else if (wr_en && bus.addr == TWM_REG_COUNT) begin
      block_r <= 1'b1;
    end else if (step) begin
      block_r <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cmp_hit[i]   = step && !block_r && (counter_value_r == cmp_act_r[i]);
      force_hit[i] = wr_en && (bus.addr == TWM_REG_FORCE)
                     && (kind != TWM_KIND_FAST) && bus.wdata[i];
    end
  end

  // compare words: buffer in pwm, straight through otherwise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        cmp_buf_r[i] <= TWM_RST_WORD;
        cmp_act_r[i] <= TWM_RST_WORD;
      end
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (bus_wr(bus, TWM_REG_CMPA + TWM_AW'(i))) begin
          cmp_buf_r[i] <= bus.wdata & fixed_mask(waveform_mode_select_r);
          if (kind != TWM_KIND_FAST) begin
            cmp_act_r[i] <= bus.wdata;
          end
        end
        if (kind == TWM_KIND_FAST && step && top_match) begin
          cmp_act_r[i] <= cmp_buf_r[i];
        end
      end
    end
  end

  // capture path keyed on waveform mode alone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_register_r <= TWM_RST_WORD;
    end else if (ce) begin
      if (capture_event && !top_is_cap(waveform_mode_select_r)) begin
        capture_register_r <= counter_value_r;
      end else if (bus_wr(bus, TWM_REG_CAPTURE)) begin
        capture_register_r <= bus.wdata;
      end
    end
  end

  always_comb begin
    flag_set = '0;
    if (kind == TWM_KIND_FAST) begin
      flag_set[TWM_FLG_OVF] = step && top_match;
    end else begin
      flag_set[TWM_FLG_OVF] = step && (counter_value_r == TWM_MAX);
    end
    for (int i = 0; i < NCH; i++) begin
      flag_set[TWM_FLG_CMP0 + i] = cmp_hit[i];
    end
    if (top_is_cmpa(waveform_mode_select_r) && step && top_match) begin
      flag_set[TWM_FLG_CMP0] = 1'b1;
    end
    flag_set[TWM_FLG_CAP] = (step && top_match && top_is_cap(waveform_mode_select_r))
                            || (capture_event && !top_is_cap(waveform_mode_select_r));
    flag_clr = bus_wr(bus, TWM_REG_FLAGS) ? bus.wdata[TWM_FLG_W-1:0] : '0;
  end

  // set beats a simultaneous write-one clear; force pulses never reach here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_r <= '0;
    end else if (ce) begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waveform_mode_select_r <= TWM_WGM_NORMAL;
    end else if (ce && bus_wr(bus, TWM_REG_CTRL)) begin
      waveform_mode_select_r <= bus.wdata[TWM_MODE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        compare_output_mode_field_r[i] <= TWM_COM_NONE;
      end
    end else if (ce && bus_wr(bus, TWM_REG_OUTMODE)) begin
      for (int i = 0; i < NCH; i++) begin
        compare_output_mode_field_r[i] <= bus.wdata[i*TWM_COM_W +: TWM_COM_W];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_value_r               <= '0;
      output_pin_direction_bit_r <= '0;
    end else if (ce && bus_wr(bus, TWM_REG_PORT)) begin
      port_value_r               <= bus.wdata[NCH-1:0];
      output_pin_direction_bit_r <= bus.wdata[TWM_PORT_DIR +: NCH];
    end
  end

  always_comb begin
    rd_mux = '0;
    case (bus.addr)
      TWM_REG_CTRL:    rd_mux[TWM_MODE_W-1:0] = waveform_mode_select_r;
      TWM_REG_OUTMODE: begin
        for (int i = 0; i < NCH; i++) begin
          rd_mux[i*TWM_COM_W +: TWM_COM_W] = compare_output_mode_field_r[i];
        end
      end
      TWM_REG_COUNT:   rd_mux = counter_value_r;
      TWM_REG_CMPA:    rd_mux = (kind == TWM_KIND_FAST) ? cmp_buf_r[0] : cmp_act_r[0];
      TWM_REG_CMPB:    rd_mux = (kind == TWM_KIND_FAST) ? cmp_buf_r[1] : cmp_act_r[1];
      TWM_REG_CAPTURE: rd_mux = capture_register_r;
      TWM_REG_FLAGS:   rd_mux[TWM_FLG_W-1:0] = flags_r;
      TWM_REG_PORT: begin
        rd_mux[NCH-1:0]            = port_value_r;
        rd_mux[TWM_PORT_DIR +: NCH] = output_pin_direction_bit_r;
      end
      TWM_REG_LATCH:   rd_mux[NCH-1:0] = latch_w;
      default:         rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_r <= '0;
    end else if (ce) begin
      rd_data_r <= bus.rd ? rd_mux : '0;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    twm_channel u_ch (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .ce         (ce),
      .match_hit  (cmp_hit[g]),
      .top_hit    (step && top_match && kind == TWM_KIND_FAST),
      .force_hit  (force_hit[g]),
      .out_mode   (compare_output_mode_field_r[g]),
      .kind       (kind),
      .toggle_ok  ((g == 0) && (waveform_mode_select_r == TWM_WGM_FAST_CMPA)),
      .port_value (port_value_r[g]),
      .direction  (output_pin_direction_bit_r[g]),
      .latch      (latch_w[g]),
      .pin        (pins[g])
    );
  end

  assign rd_data = rd_data_r;
  assign flags   = flags_r;

endmodule : twm_top

`default_nettype wire

// File: twm_top_assertions.sv
/*
  concurrent checks on the ports of twm_top, attached by bind.
  assumes one clock domain, synchronous active-high reset.
*/
`default_nettype none

module twm_top_chk
  import twm_pkg::*;
#(
  parameter int unsigned NCH = TWM_NCH
) (
  input wire logic             clk_sys,
  input wire logic             rst,
  input wire logic             ce,
  input wire logic             tick,
  input wire twm_bus_req_type  bus,
  input wire logic             capture_event,
  input wire logic [TWM_DW-1:0]    rd_data,
  input wire logic [TWM_FLG_W-1:0] flags,
  input wire twm_pin_type [NCH-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_reset_clear:
    assert property (disable iff (1'b0) rst |=> flags == '0 && rd_data == '0 && pins == '0)
    else $error("state not cleared by reset");
  // pins are registered, so the direction shows two edges after the write
  a_dir_to_oe:
    assert property ((ce && bus.wr && bus.addr == TWM_REG_PORT) ##1 ce
      |=> pins[0].oe == $past(bus.wdata[TWM_PORT_DIR], 2))
    else $error("pin enable does not follow direction bit");
  a_force_no_flag:
    assert property (ce && bus.wr && bus.addr == TWM_REG_FORCE && !tick && !capture_event
      |=> $stable(flags))
    else $error("forced compare changed a flag");
  a_freeze_hold:
    assert property (!ce |=> $stable(flags) && $stable(pins) && $stable(rd_data))
    else $error("outputs moved while clock enable low");
  // ce needed in the first cycle too: a frozen cycle delays a pending pin update
  a_latch_needs_tick:
    assert property ((ce && !tick && !bus.wr) ##1 ce |=> $stable(pins))
    else $error("pin changed without tick or write");
  a_ovf_on_tick:
    assert property ($rose(flags[TWM_FLG_OVF]) |-> $past(tick && ce))
    else $error("overflow flag set without tick");
  a_cmp_on_tick:
    assert property ($rose(flags[TWM_FLG_CMP0]) |-> $past(tick && ce))
    else $error("compare flag set without tick");
  a_flag_set_only:
    assert property ($fell(flags[TWM_FLG_OVF]) |-> $past(rst)
      || $past(ce && bus.wr && bus.addr == TWM_REG_FLAGS && bus.wdata[TWM_FLG_OVF]))
    else $error("overflow flag cleared by hardware");
endmodule : twm_top_chk

bind twm_top twm_top_chk #(.NCH(NCH)) u_chk (
  .clk_sys      (clk_sys),
  .rst          (rst),
  .ce           (ce),
  .tick         (tick),
  .bus          (bus),
  .capture_event(capture_event),
  .rd_data      (rd_data),
  .flags        (flags),
  .pins         (pins)
);

`default_nettype wire

// File: twm_load.sv
/*
  external load on the two compare pins.
  assumes no pull resistor: a released line drifts, shown as the inverse.
*/
`default_nettype none

module twm_load
  import twm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire twm_pin_type [1:0] pins,
  output logic [1:0]             level
);
  timeunit 1ns;
  timeprecision 1ps;

  // floating line must not look like a held value
  always @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      level[i] <= pins[i].oe ? pins[i].out : ~level[i];
    end
  end
endmodule : twm_load

`default_nettype wire

// File: test_timer16_waveform_modes.sv
/*
  self-checking bench for twm_top with a load on its pins.
  assumes 125 MHz clock and register reads answered one cycle later.
*/
`default_nettype none

module test_timer16_waveform_modes
  import twm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk_sys       = 1'b0;
  logic                 rst           = 1'b1;
  logic                 ce            = 1'b1;
  logic                 tick          = 1'b0;
  logic                 capture_event = 1'b0;
  twm_bus_req_type      bus           = '0;
  logic [TWM_DW-1:0]    rd_data;
  logic [TWM_FLG_W-1:0] flags;
  twm_pin_type [1:0]    pins;
  logic [1:0]           level;
  logic [15:0]          exp_q[$];
  logic                 rd_seen       = 1'b0;
  logic [15:0]          lfsr          = 16'h97e8;
  int                   bad_count     = 0;
  int                   tests_run     = 0;

  always #4 clk_sys = ~clk_sys;

  twm_top #(.NCH(2)) dut (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .ce           (ce),
    .tick         (tick),
    .bus          (bus),
    .capture_event(capture_event),
    .rd_data      (rd_data),
    .flags        (flags),
    .pins         (pins)
  );

  twm_load u_load (
    .clk_sys(clk_sys),
    .pins   (pins),
    .level  (level)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic put(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask : put

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    put(a, d, 1'b1, 1'b0);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    put(a, 16'h0000, 1'b0, 1'b1);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) put(4'h0, 16'h0000, 1'b0, 1'b0);
  endtask : idle

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      tick <= 1'b1;
    end
    @(posedge clk_sys);
    tick <= 1'b0;
  endtask : ticks

  // read data is only valid in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      check(rd_data, exp_q.pop_front());
    end
    rd_seen <= bus.rd && ce && !rst;
  end

  initial begin : main
    logic [3:0]  modes [5];
    logic [15:0] tops [5];
    modes = '{TWM_WGM_FAST_8, TWM_WGM_FAST_9, TWM_WGM_FAST_10, TWM_WGM_FAST_CAP,
              TWM_WGM_FAST_CMPA};
    tops = '{TWM_TOP_8, TWM_TOP_9, TWM_TOP_10, TWM_MAX, TWM_MAX};
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(TWM_REG_FLAGS, 16'h0000);
    rd(TWM_REG_LATCH, 16'h0000);
    rd(4'hf, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(TWM_REG_COUNT, lfsr);
      rd(TWM_REG_COUNT, lfsr);
    end
    wr(TWM_REG_COUNT, 16'hfffe);
    ticks(2);
    rd(TWM_REG_COUNT, TWM_BOTTOM);
    rd(TWM_REG_FLAGS, 16'h0001);
    wr(TWM_REG_FLAGS, 16'h000f);
    rd(TWM_REG_FLAGS, 16'h0000);
    wr(TWM_REG_PORT, 16'h0004);
    wr(TWM_REG_CMPA, 16'h0002);
    wr(TWM_REG_CTRL, {12'h000, TWM_WGM_CTC_CMPA});
    wr(TWM_REG_OUTMODE, {14'h0, TWM_COM_TOGGLE});
    ticks(3);
    rd(TWM_REG_COUNT, TWM_BOTTOM);
    rd(TWM_REG_FLAGS, 16'h0006);
    rd(TWM_REG_LATCH, 16'h0001);
    ticks(3);
    rd(TWM_REG_LATCH, 16'h0000);
    wr(TWM_REG_FLAGS, 16'h000f);
    wr(TWM_REG_FORCE, 16'h0001);
    rd(TWM_REG_LATCH, 16'h0001);
    rd(TWM_REG_FLAGS, 16'h0000);
    rd(TWM_REG_COUNT, TWM_BOTTOM);
    idle(2);
    @(negedge clk_sys);
    check(16'({pins[1].oe, pins[0].oe, level[0]}), 16'h0003);
    wr(TWM_REG_OUTMODE, {14'h0, TWM_COM_CLEAR});
    rd(TWM_REG_LATCH, 16'h0001);
    ticks(3);
    rd(TWM_REG_LATCH, 16'h0000);
    wr(TWM_REG_FLAGS, 16'h000f);
    wr(TWM_REG_COUNT, 16'hfffd);
    ticks(3);
    rd(TWM_REG_COUNT, TWM_BOTTOM);
    rd(TWM_REG_FLAGS, 16'h0001);
    wr(TWM_REG_CTRL, {12'h000, TWM_WGM_CTC_CAP});
    wr(TWM_REG_CAPTURE, 16'h0003);
    wr(TWM_REG_FLAGS, 16'h000f);
    ticks(4);
    rd(TWM_REG_COUNT, TWM_BOTTOM);
    rd(TWM_REG_FLAGS, 16'h000e);
    wr(TWM_REG_CTRL, 16'h0000);
    wr(TWM_REG_OUTMODE, 16'h000f);
    wr(TWM_REG_FLAGS, 16'h000f);
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    capture_event <= 1'b1;
    @(posedge clk_sys);
    capture_event <= 1'b0;
    rd(TWM_REG_FLAGS, 16'h0008);
    rd(TWM_REG_CAPTURE, TWM_BOTTOM);
    wr(TWM_REG_CTRL, {12'h000, TWM_WGM_FAST_8});
    wr(TWM_REG_OUTMODE, {14'h0, TWM_COM_SET});
    wr(TWM_REG_CMPA, 16'h0010);
    wr(TWM_REG_COUNT, 16'h00fe);
    wr(TWM_REG_FLAGS, 16'h000f);
    ticks(2);
    rd(TWM_REG_COUNT, TWM_BOTTOM);
    rd(TWM_REG_FLAGS, 16'h0001);
    rd(TWM_REG_LATCH, 16'h0001);
    ticks(17);
    rd(TWM_REG_COUNT, 16'h0011);
    rd(TWM_REG_FLAGS, 16'h0007);
    rd(TWM_REG_LATCH, 16'h0000);
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    ce <= 1'b0;
    wr(TWM_REG_COUNT, 16'h1234);
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    ce <= 1'b1;
    rd(TWM_REG_COUNT, 16'h0011);
    for (int i = 0; i < 5; i++) begin
      wr(TWM_REG_CTRL, {12'h000, modes[i]});
      wr(TWM_REG_CMPA, 16'hffff);
      rd(TWM_REG_CMPA, tops[i]);
    end
    wr(TWM_REG_OUTMODE, {14'h0, TWM_COM_TOGGLE});
    wr(TWM_REG_CMPA, 16'h0003);
    wr(TWM_REG_COUNT, 16'h000f);
    wr(TWM_REG_FLAGS, 16'h000f);
    ticks(2);
    rd(TWM_REG_FLAGS, 16'h0003);
    rd(TWM_REG_LATCH, 16'h0001);
    ticks(4);
    rd(TWM_REG_COUNT, TWM_BOTTOM);
    rd(TWM_REG_LATCH, 16'h0000);
    ticks(4);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(TWM_REG_LATCH, 16'h0000);
    rd(TWM_REG_FLAGS, 16'h0000);
    idle(3);
    check(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule : test_timer16_waveform_modes

`default_nettype wire
